//--- dv/spk_host_model.sv
/*
  Host model of the loop controller: issues commands and settings as
  one-cycle register strobes.
  Assumes the bench clock and a slave that never makes it wait.
*/
`timescale 1ns/1ns
module spk_host_model (
  input  wire logic        clk_i,
  output logic      [3:0]  addr_o,
  output logic      [15:0] wr_data_o,
  output logic             wr_en_o,
  output logic             rd_en_o
);
  initial begin
    addr_o    = 4'h0;
    wr_data_o = 16'h0000;
    wr_en_o   = 1'b0;
    rd_en_o   = 1'b0;
  end

  // The bench calls this also with line talk active and with the loop at 0 dB.
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_o    <= a;
    wr_data_o <= d;
    wr_en_o   <= 1'b1;
    @(posedge clk_i);
    wr_en_o   <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a);
    @(posedge clk_i);
    addr_o  <= a;
    rd_en_o <= 1'b1;
    @(posedge clk_i);
    rd_en_o <= 1'b0;
  endtask : rd
endmodule : spk_host_model

//--- dv/tb.sv
/*
  Bench of the loop controller: drives the voice, tone and canceller
  inputs, commands through the host model, checks outputs and reads.
  Assumes the shortened timing parameters set below.
*/
`timescale 1ns/1ns
`define CHK(nm, e, g) begin \
  n_checks++; \
  if ((g) !== (e)) begin \
    errors++; \
    $display("wrong value %s exp %0h got %0h", nm, e, g); \
  end \
end
module tb;
  import spk_pkg::*;
  logic        clk_i = 1'b0, rst_n_i = 1'b0;
  logic        line_talk_i = 1'b0, mic_talk_i = 1'b0, tone_i = 1'b0;
  logic        abnormal_i = 1'b0, aec_stable_i = 1'b0;
  logic [7:0]  quality_i = 8'h00, np, nc;
  logic [3:0]  addr, sv, se;
  logic [15:0] wdat, rd_data_o, exp_v, v;
  logic        wr_en, rd_en, rd_d = 1'b0;
  spk_state_t  state_o;
  logic        half_duplex_o, train_pulse_o, lec_capture_o, aec_adapt_o;
  logic        spk_mute_o, mic_mute_o;
  logic [5:0]  rx_att_o, tx_att_o, prev;
  logic [2:0]  line_vol_o, lv;
  logic [3:0]  spk_vol_o;
  logic [7:0]  aec_span_o;
  logic [15:0] exp_q[$];
  int          errors = 0, n_checks = 0, seed = 15, nsteps;

  always #10 clk_i = ~clk_i;

  spk_host_model host (.clk_i(clk_i), .addr_o(addr), .wr_data_o(wdat),
                       .wr_en_o(wr_en), .rd_en_o(rd_en));

  spk_loop_ctrl #(.TRAIN_CYC(16), .LEC_CYC(24), .TONE_CYC(40), .STEP_CYC(8)) uut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr), .wr_data_i(wdat),
    .wr_en_i(wr_en), .rd_en_i(rd_en), .rd_data_o(rd_data_o),
    .line_talk_i(line_talk_i), .mic_talk_i(mic_talk_i), .tone_i(tone_i),
    .abnormal_i(abnormal_i), .aec_stable_i(aec_stable_i), .quality_i(quality_i),
    .state_o(state_o), .half_duplex_o(half_duplex_o), .train_pulse_o(train_pulse_o),
    .lec_capture_o(lec_capture_o), .aec_adapt_o(aec_adapt_o), .rx_att_o(rx_att_o),
    .tx_att_o(tx_att_o), .line_vol_o(line_vol_o), .spk_vol_o(spk_vol_o),
    .spk_mute_o(spk_mute_o), .mic_mute_o(mic_mute_o), .aec_span_o(aec_span_o));

  ////////////////////////////////////////////////////////////////////////////
  // Read data stands only in the cycle after the strobe.
  always @(posedge clk_i) begin
    if (rd_d) begin
      exp_v = exp_q.pop_front();
      `CHK("rd_data", exp_v, rd_data_o)
    end
    rd_d = rd_en;
  end

  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    host.rd(a);
  endtask : rd

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    #200000;
    errors++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(11);
    `CHK("state", SPK_OFF, state_o)
    `CHK("half", 1'b1, half_duplex_o)
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    tick(2);
    `CHK("span", 8'h50, aec_span_o)
    rd(4'h0, 16'h0004);
    rd(4'h1, 16'h0003);
    host.wr(4'h0, 16'h000D);
    tick(3);
    `CHK("state", SPK_HALF, state_o)
    `CHK("pulse", 1'b0, train_pulse_o)
    rd(4'h3, 16'h00C1);
    line_talk_i <= 1'b1;
    tick(2);
    `CHK("tx", 6'd24, tx_att_o)
    `CHK("rx", 6'd0, rx_att_o)
    `CHK("adapt", 1'b1, aec_adapt_o)
    @(posedge clk_i);
    line_talk_i <= 1'b0;
    mic_talk_i  <= 1'b1;
    tick(2);
    `CHK("rx", 6'd24, rx_att_o)
    `CHK("tx", 6'd0, tx_att_o)
    `CHK("adapt", 1'b0, aec_adapt_o)
    @(posedge clk_i);
    mic_talk_i <= 1'b0;
    quality_i  <= 8'($random(seed));
    tick(4);
    host.wr(4'h0, 16'h000D);
    np = 8'h00;
    nc = 8'h00;
    repeat (60) begin
      #1;
      np += train_pulse_o;
      nc += lec_capture_o;
      @(posedge clk_i);
    end
    #1;
    `CHK("pulse_len", 8'd16, np)
    `CHK("capture_len", 8'd24, nc)
    `CHK("state", SPK_FULL, state_o)
    `CHK("half", 1'b0, half_duplex_o)
    host.wr(4'h4, 16'h00FF);
    host.wr(4'h9, 16'h1234);
    rd(4'h4, {8'h00, quality_i});
    rd(4'h9, 16'h0000);
    quality_i <= 8'($random(seed));
    host.wr(4'h0, 16'h000D);
    tick(1);
    `CHK("state", SPK_TRAIN, state_o)
    `CHK("pulse", 1'b1, train_pulse_o)
    `CHK("half", 1'b1, half_duplex_o)
    tick(24);
    `CHK("state", SPK_FULL, state_o)
    rd(4'h4, {8'h00, quality_i});
    host.wr(4'h1, 16'h0000);
    line_talk_i <= 1'b1;
    abnormal_i  <= 1'b1;
    tick(3);
    `CHK("tx", 6'd12, tx_att_o)
    rd(4'h3, 16'h00C3);
    abnormal_i   <= 1'b0;
    aec_stable_i <= 1'b1;
    nsteps = 0;
    prev = 6'd12;
    repeat (40) begin
      tick(1);
      if (tx_att_o !== prev) begin
        `CHK("step", prev - 6'd4, tx_att_o)
        nsteps++;
        prev = tx_att_o;
      end
    end
    `CHK("steps", 3, nsteps)
    host.wr(4'h1, 16'h0007);
    tick(2);
    `CHK("tx", 6'd28, tx_att_o)
    @(posedge clk_i);
    line_talk_i <= 1'b0;
    mic_talk_i  <= 1'b1;
    tick(2);
    `CHK("rx", 6'd28, rx_att_o)
    @(posedge clk_i);
    tone_i <= 1'b1;
    tick(20);
    `CHK("rx", 6'd28, rx_att_o)
    tick(30);
    `CHK("rx", 6'd0, rx_att_o)
    `CHK("tx", 6'd28, tx_att_o)
    rd(4'h3, 16'h000B);
    tone_i <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      v = 16'($random(seed));
      if (i == 0) v[7:4] = 4'hF;
      if (i == 1) v[2:0] = 3'h7;
      lv = (v[2:0] > 3'h4) ? 3'h4 : v[2:0];
      sv = v[7:4];
      se = (sv > 4'hE) ? 4'hE : sv;
      host.wr(4'h2, {6'h00, v[9:8], sv, 1'b0, v[2:0]});
      tick(2);
      `CHK("line_vol", lv, line_vol_o)
      `CHK("spk_vol", se, spk_vol_o)
      `CHK("spk_mute", v[8], spk_mute_o)
      `CHK("mic_mute", v[9], mic_mute_o)
      rd(4'h2, {6'h00, v[9:8], se, 1'b0, lv});
    end
    host.wr(4'h0, 16'h0003);
    abnormal_i <= 1'b1;
    tick(3);
    `CHK("rx", 6'd40, rx_att_o)
    @(posedge clk_i);
    abnormal_i <= 1'b0;
    tick(3);
    `CHK("rx", 6'd28, rx_att_o)
    host.wr(4'h0, 16'h0001);
    abnormal_i <= 1'b1;
    tick(3);
    `CHK("rx", 6'd28, rx_att_o)
    @(posedge clk_i);
    abnormal_i <= 1'b0;
    host.wr(4'h0, 16'h0004);
    tick(3);
    `CHK("state", SPK_OFF, state_o)
    `CHK("rx", 6'd0, rx_att_o)
    `CHK("tx", 6'd0, tx_att_o)
    tick(2);
    tally_and_finish();
  end
endmodule : tb

//--- rtl/spk_consts.svh
/*
  Register offsets, field positions, reset values and timing figures of the
  speakerphone loop controller.
  Assumes a 50 MHz system clock and an 8 kHz codec sample rate.
*/
`ifndef SPK_CONSTS_SVH
`define SPK_CONSTS_SVH

`define SPK_ADDR_CTRL    4'h0
`define SPK_ADDR_LOOP    4'h1
`define SPK_ADDR_VOL     4'h2
`define SPK_ADDR_STATUS  4'h3
`define SPK_ADDR_QF      4'h4

`define SPK_CTRL_EN      0
`define SPK_CTRL_MODE_LO 1
`define SPK_CTRL_MODE_HI 2
`define SPK_CTRL_TRAIN   3
`define SPK_VOL_LINE_HI  2
`define SPK_VOL_SPK_LO   4
`define SPK_VOL_SPK_HI   7
`define SPK_VOL_SPK_MUTE 8
`define SPK_VOL_MIC_MUTE 9

`define SPK_LOOP_RST     3'h3
`define SPK_MODE_RST     2'h2
`define SPK_LVOL_MAX     3'h4
`define SPK_SVOL_MAX     4'hE
`define SPK_EXTRA_MAX    4'hC
`define SPK_EXTRA_STEP   4'h4

`define SPK_CLK_KHZ      50000
`define SPK_SAMPLE_KHZ   8
`define SPK_TRAIN_MS     16
`define SPK_LEC_MS       23
`define SPK_AEC_MS       10
`define SPK_TONE_MS      1000
`define SPK_STEP_MS      250

`endif

//--- rtl/spk_loop_ctrl.sv
/*
  Speakerphone loop controller: duplex sequencing, line canceller training,
  loop attenuation distribution, tone priority, volume and mute registers.
  Assumes voice detector, tone, canceller status and quality inputs come from
  logic on the same clock, and a host on the plain register port.
*/
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
`include "spk_consts.svh"

module spk_loop_ctrl #(
  parameter int unsigned CNT_W     = 26,
  parameter int unsigned TRAIN_CYC = `SPK_TRAIN_MS * `SPK_CLK_KHZ,
  parameter int unsigned LEC_CYC   = `SPK_LEC_MS * `SPK_CLK_KHZ,
  parameter int unsigned TONE_CYC  = `SPK_TONE_MS * `SPK_CLK_KHZ,
  parameter int unsigned STEP_CYC  = `SPK_STEP_MS * `SPK_CLK_KHZ
) (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic [3:0]        addr_i,
  input  wire logic [15:0]       wr_data_i,
  input  wire logic              wr_en_i,
  input  wire logic              rd_en_i,
  output logic      [15:0]       rd_data_o,
  input  wire logic              line_talk_i,
  input  wire logic              mic_talk_i,
  input  wire logic              tone_i,
  input  wire logic              abnormal_i,
  input  wire logic              aec_stable_i,
  input  wire logic [7:0]        quality_i,
  output spk_pkg::spk_state_t    state_o,
  output logic                   half_duplex_o,
  output logic                   train_pulse_o,
  output logic                   lec_capture_o,
  output logic                   aec_adapt_o,
  output logic      [5:0]        rx_att_o,
  output logic      [5:0]        tx_att_o,
  output logic      [2:0]        line_vol_o,
  output logic      [3:0]        spk_vol_o,
  output logic                   spk_mute_o,
  output logic                   mic_mute_o,
  output logic      [7:0]        aec_span_o
);
  import spk_pkg::*;

  localparam logic [7:0] AEC_TAPS = 8'(`SPK_AEC_MS * `SPK_SAMPLE_KHZ);
  localparam logic [CNT_W-1:0] TRAIN_END = CNT_W'(TRAIN_CYC - 1);
  localparam logic [CNT_W-1:0] LEC_END   = CNT_W'(LEC_CYC - 1);
  localparam logic [CNT_W-1:0] TONE_END  = CNT_W'(TONE_CYC - 1);
  localparam logic [CNT_W-1:0] STEP_END  = CNT_W'(STEP_CYC - 1);

  //////////////////////////////////////////////////////////////////////////
  spk_state_t       state_r, state_nxt;
  spk_adj_t         mode_r;
  logic             en_r, dir_mic_r, tone_prio_r;
  logic [2:0]       loop_r;
  logic [3:0]       extra_r, extra_nxt;
  logic [7:0]       qf_r;
  logic [CNT_W-1:0] tcnt_r, tone_cnt_r, step_cnt_r;

  // Register decode and host commands.
  wire wr_ctrl  = wr_en_i && (addr_i == `SPK_ADDR_CTRL);
  wire wr_loop  = wr_en_i && (addr_i == `SPK_ADDR_LOOP);
  wire wr_vol   = wr_en_i && (addr_i == `SPK_ADDR_VOL);
  wire train_go = wr_ctrl && wr_data_i[`SPK_CTRL_TRAIN];
  wire [2:0] lvol_w = wr_data_i[`SPK_VOL_LINE_HI:0];
  wire [3:0] svol_w = wr_data_i[`SPK_VOL_SPK_HI:`SPK_VOL_SPK_LO];

  //////////////////////////////////////////////////////////////////////////
  // Duplex sequencing.
  wire train_done = (state_r == SPK_TRAIN) && (tcnt_r == LEC_END);
  wire entering   = (state_r != SPK_TRAIN) && (state_nxt == SPK_TRAIN);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SPK_OFF:   if (en_r) state_nxt = SPK_HALF;
      SPK_HALF:  begin
        if (!en_r) state_nxt = SPK_OFF;
        else if (train_go) state_nxt = SPK_TRAIN;
      end
      SPK_TRAIN: begin
        if (!en_r) state_nxt = SPK_OFF;
        else if (train_done) state_nxt = SPK_FULL;
      end
      SPK_FULL:  begin
        if (!en_r) state_nxt = SPK_OFF;
        else if (train_go) state_nxt = SPK_TRAIN;
      end
      default:   state_nxt = SPK_OFF;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_r <= SPK_OFF;
      tcnt_r  <= '0;
    end else begin
      state_r <= state_nxt;
      tcnt_r  <= (state_r == SPK_TRAIN && !entering) ? tcnt_r + 1'b1 : '0;
    end
  end

  wire pulse_nxt = entering ? 1'b1 :
                   (tcnt_r == TRAIN_END || state_nxt != SPK_TRAIN) ? 1'b0 :
                   train_pulse_o;

  //////////////////////////////////////////////////////////////////////////
  // Tone priority and talk direction.
  wire line_v = line_talk_i && !tone_i;
  wire mic_v  = mic_talk_i && !tone_i;
  wire dir_mic_nxt = tone_prio_r ? 1'b0 :
                     (line_v && !mic_v) ? 1'b0 :
                     (mic_v && !line_v) ? 1'b1 : dir_mic_r;
  wire [5:0] total_w = 6'({loop_r, 2'b00}) + 6'(extra_r);
  wire [5:0] rx_nxt  = (state_nxt == SPK_OFF || !dir_mic_nxt) ? 6'h00 : total_w;
  wire [5:0] tx_nxt  = (state_nxt == SPK_OFF) ? 6'h00 : total_w - rx_nxt;

  //////////////////////////////////////////////////////////////////////////
  // Extra loop attenuation and its step-down divider.
  wire adj_on   = (mode_r == SPK_ADJ_HOLD) || (mode_r == SPK_ADJ_AUTO);
  wire step_run = (mode_r == SPK_ADJ_AUTO) && (extra_r != 4'h0) &&
                  !abnormal_i && aec_stable_i;
  wire step_tk  = step_run && (step_cnt_r == STEP_END);

  always_comb begin
    extra_nxt = extra_r;
    if (state_nxt == SPK_OFF || !adj_on)
      extra_nxt = 4'h0;
    else if (state_r == SPK_OFF && mode_r == SPK_ADJ_AUTO)
      extra_nxt = `SPK_EXTRA_MAX;
    else if (abnormal_i)
      extra_nxt = `SPK_EXTRA_MAX;
    else if (mode_r == SPK_ADJ_HOLD)
      extra_nxt = 4'h0;
    else if (step_tk)
      extra_nxt = extra_r - `SPK_EXTRA_STEP;
  end

  //////////////////////////////////////////////////////////////////////////
  // Host registers.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      en_r       <= 1'b0;
      mode_r     <= spk_adj_t'(`SPK_MODE_RST);
      loop_r     <= `SPK_LOOP_RST;
      line_vol_o <= 3'h0;
      spk_vol_o  <= 4'h0;
      spk_mute_o <= 1'b0;
      mic_mute_o <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        en_r   <= wr_data_i[`SPK_CTRL_EN];
        mode_r <= spk_adj_t'(wr_data_i[`SPK_CTRL_MODE_HI:`SPK_CTRL_MODE_LO]);
      end
      if (wr_loop) loop_r <= wr_data_i[2:0];
      if (wr_vol) begin
        line_vol_o <= (lvol_w > `SPK_LVOL_MAX) ? `SPK_LVOL_MAX : lvol_w;
        spk_vol_o  <= (svol_w > `SPK_SVOL_MAX) ? `SPK_SVOL_MAX : svol_w;
        spk_mute_o <= wr_data_i[`SPK_VOL_SPK_MUTE];
        mic_mute_o <= wr_data_i[`SPK_VOL_MIC_MUTE];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Datapath state and outputs.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tone_cnt_r    <= '0;
      tone_prio_r   <= 1'b0;
      step_cnt_r    <= '0;
      extra_r       <= 4'h0;
      dir_mic_r     <= 1'b0;
      qf_r          <= 8'h00;
      train_pulse_o <= 1'b0;
      half_duplex_o <= 1'b1;
      lec_capture_o <= 1'b0;
      aec_adapt_o   <= 1'b0;
      rx_att_o      <= 6'h00;
      tx_att_o      <= 6'h00;
      aec_span_o    <= 8'h00;
    end else begin
      tone_cnt_r    <= (tone_i && tone_cnt_r != TONE_END) ? tone_cnt_r + 1'b1 :
                       (tone_i ? tone_cnt_r : '0);
      tone_prio_r   <= tone_i && (tone_cnt_r == TONE_END);
      step_cnt_r    <= (step_run && !step_tk) ? step_cnt_r + 1'b1 : '0;
      extra_r       <= extra_nxt;
      dir_mic_r     <= dir_mic_nxt;
      qf_r          <= train_done ? quality_i : qf_r;
      train_pulse_o <= pulse_nxt;
      half_duplex_o <= (state_nxt != SPK_FULL);
      lec_capture_o <= (state_nxt == SPK_TRAIN);
      aec_adapt_o   <= (state_nxt != SPK_OFF) && line_v && !mic_v;
      rx_att_o      <= rx_nxt;
      tx_att_o      <= tx_nxt;
      aec_span_o    <= AEC_TAPS;
    end
  end

  assign state_o       = state_r;

  //////////////////////////////////////////////////////////////////////////
  // Read port: data stand for exactly the cycle after the strobe.
  wire [15:0] rd_mux =
    (addr_i == `SPK_ADDR_CTRL)   ? {12'h000, 1'b0, mode_r, en_r} :
    (addr_i == `SPK_ADDR_LOOP)   ? {13'h0000, loop_r} :
    (addr_i == `SPK_ADDR_VOL)    ? {6'h00, mic_mute_o, spk_mute_o, spk_vol_o,
                                    1'b0, line_vol_o} :
    (addr_i == `SPK_ADDR_STATUS) ? {8'h00, extra_r, tone_prio_r,
                                    train_pulse_o, state_r} :
    (addr_i == `SPK_ADDR_QF)     ? {8'h00, qf_r} : 16'h0000;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) rd_data_o <= 16'h0000;
    else          rd_data_o <= rd_en_i ? rd_mux : 16'h0000;
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks.
  sequence train_start_s;
    !train_pulse_o ##1 train_pulse_o;
  endsequence

  start_half_a : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_r == SPK_OFF && en_r |=> state_r == SPK_HALF)
    else $error("start did not enter half duplex");
  full_after_train_a : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_r != SPK_FULL ##1 state_r == SPK_FULL |-> $past(train_done))
    else $error("full duplex without training");
  train_cmd_a : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_r && state_r == SPK_HALF && train_go |=> train_pulse_o && lec_capture_o)
    else $error("training command sent no pulse");
  pulse_start_a : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    train_start_s |-> state_r == SPK_TRAIN && tcnt_r == '0)
    else $error("training pulse started off count");
  pulse_len_a : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    train_pulse_o && tcnt_r == TRAIN_END |=> !train_pulse_o)
    else $error("training pulse length wrong");
  half_flag_a : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    half_duplex_o != (state_r == SPK_FULL))
    else $error("half duplex flag disagrees with state");
  lec_window_a : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_r == SPK_TRAIN && tcnt_r == LEC_END |=> state_r != SPK_TRAIN)
    else $error("echo capture window length wrong");
  extra_start_a : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_r == SPK_OFF && state_nxt != SPK_OFF && mode_r == SPK_ADJ_AUTO |=>
    extra_r == `SPK_EXTRA_MAX)
    else $error("start-up extra attenuation missing");
  off_quiet_a : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_r == SPK_OFF |-> rx_att_o == 6'h00 && tx_att_o == 6'h00)
    else $error("attenuation active while off");
  pulse_hold_a : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    train_pulse_o && state_r == SPK_TRAIN && tcnt_r < TRAIN_END && en_r &&
    !train_go |=> train_pulse_o)
    else $error("training pulse ended early");
  sum_const_a : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_r == SPK_HALF |-> 6'(rx_att_o + tx_att_o) == $past(total_w))
    else $error("loop attenuation sum not kept");
  quiet_side_a : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_nxt != SPK_OFF && line_v && !mic_v && !tone_prio_r |=>
    rx_att_o == 6'h00 && tx_att_o == $past(total_w))
    else $error("line talk did not attenuate transmit");
  adapt_gate_a : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    aec_adapt_o |-> $past(line_talk_i && !mic_talk_i && !tone_i))
    else $error("adaptation outside line-only talk");
  abnormal_a : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    abnormal_i && adj_on && state_nxt != SPK_OFF |=> extra_r == `SPK_EXTRA_MAX)
    else $error("abnormal extra attenuation missing");
  step_down_a : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    step_tk && !abnormal_i && state_nxt != SPK_OFF && state_r != SPK_OFF |=>
    extra_r == $past(extra_r) - `SPK_EXTRA_STEP)
    else $error("extra attenuation step wrong");
  tone_prio_a : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tone_prio_r && state_r != SPK_OFF |=> rx_att_o == 6'h00)
    else $error("tone did not give line priority");
  read_once_a : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !rd_en_i |=> rd_data_o == 16'h0000)
    else $error("read data outside answer cycle");
endmodule : spk_loop_ctrl

//--- rtl/spk_pkg.sv
/*
  Types shared by the speakerphone loop controller.
  Assumes nothing beyond a SystemVerilog package scope.
*/
package spk_pkg;
  typedef enum logic [1:0] {
    SPK_OFF   = 2'b00,
    SPK_HALF  = 2'b01,
    SPK_TRAIN = 2'b10,
    SPK_FULL  = 2'b11
  } spk_state_t;

  typedef enum logic [1:0] {
    SPK_ADJ_NONE = 2'b00,
    SPK_ADJ_HOLD = 2'b01,
    SPK_ADJ_AUTO = 2'b10,
    SPK_ADJ_RSVD = 2'b11
  } spk_adj_t;
endpackage : spk_pkg
